// ===== core/rms_cfg.svh
// Constants: register offsets, fields, reset values, clock and output rates and timeout for the mode sequencer
`ifndef RMS_CFG_SVH
`define RMS_CFG_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RMS_OFF_CTRL    8'h00
`define RMS_OFF_SVCFG   8'h04
`define RMS_OFF_STAT    8'h08
`define RMS_OFF_MSGTYPE 8'h0C
`define RMS_OFF_FILTER  8'h10
`define RMS_OFF_BASEOUT 8'h14
// ****************************************
// Control register fields
// ****************************************
`define RMS_CTRL_ROLE      0
`define RMS_CTRL_FLOATONLY 1
`define RMS_CTRL_CMDGO     2
`define RMS_CTRL_MODE_LO   3
`define RMS_CTRL_MODE_HI   4
`define RMS_CTRL_COORD     5
`define RMS_CTRL_GNSS_LO   6
`define RMS_CTRL_GNSS_HI   7
`define RMS_CTRL_RESET     8'hC0
// ****************************************
// Mode and constellation codes
// ****************************************
`define RMS_BMODE_NONE   2'h0
`define RMS_BMODE_SURVEY 2'h1
`define RMS_BMODE_FIXED  2'h2
`define RMS_GNSS_GPS     2'h0
`define RMS_GNSS_GPS_BDS 2'h1
`define RMS_GNSS_GPS_GLO 2'h3
// ****************************************
// Timing
// ****************************************
`define RMS_CLK_HZ       20000000
`define RMS_OUT_RATE_HZ  1
`define RMS_BLINK_HZ     2
`define RMS_CORR_TMO_MS  2000
`define RMS_SVTIME_RESET 16'h003C
`define RMS_SVACC_RESET  16'h0100
`define RMS_MINSIG_RESET 4'h4
`endif

// ===== core/rms_pkg.sv
// Package: types shared by the mode sequencer
package rms_pkg;
	// Rover solution states
	typedef enum logic [1:0] {
		RMS_ROV_STD,
		RMS_ROV_FLOAT,
		RMS_ROV_FIXED
	} rms_rov_t;
	// Base operating states
	typedef enum logic [1:0] {
		RMS_BASE_STD,
		RMS_BASE_SURVEY,
		RMS_BASE_FIXED
	} rms_base_t;
	// Receiver status inputs from the tracking engine
	typedef struct packed {
		logic       corr_valid;  // Pulse: one valid correction frame
		logic [11:0] msg_type;   // Type of that frame
		logic       amb_resolved; // Ambiguities resolved
		logic [3:0] locked_sigs; // Signals in carrier lock
		logic       bit_sync;    // Data bit sync reached
		logic       tow_valid;   // Time of week known
		logic       frame_sync;  // Frame sync reached
		logic       pos_valid;   // Position estimate pulse
		logic [15:0] pos_acc;    // Estimate accuracy
	} rms_rx_t;
endpackage : rms_pkg

// ===== core/rms_mode_seq.sv
// Design: rover and base mode sequencer with Wishbone register slave
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rms_cfg.svh"
module rms_mode_seq
	import rms_pkg::*;
#(
	parameter int CLK_HZ    = `RMS_CLK_HZ,
	parameter int CORR_TMO_MS = `RMS_CORR_TMO_MS
) (
	input  wire logic        clk_i,         // System clock
	input  wire logic        rst_i,         // Synchronous reset
	input  wire logic        wb_cyc_i,      // Wishbone cycle
	input  wire logic        wb_stb_i,      // Wishbone strobe
	input  wire logic        wb_we_i,       // Write enable
	input  wire logic [7:0]  wb_adr_i,      // Byte address
	input  wire logic [3:0]  wb_sel_i,      // Byte lanes
	input  wire logic [31:0] wb_dat_i,      // Write data
	output logic      [31:0] wb_dat_o,      // Read data
	output logic             wb_ack_o,      // Acknowledge
	input  wire rms_rx_t     rx_i,          // Tracking engine status
	output logic             corr_status_n_o, // Correction status pin, active low
	output logic             raw_meas_en_o,   // Raw measurement output allowed
	output logic             nav_payload_en_o, // Payload output allowed
	output logic             ned_rel_o,       // Report as NED relative vector
	output logic             coord_ecef_o,    // Coordinate format is ECEF
	output logic [1:0]       gnss_sel_o,      // Constellation selection
	output logic             base_msg_stb_o,  // Base emits one message
	output logic [11:0]      base_msg_type_o  // Type of emitted message
);
	// ****************************************
	// Derived timing counts
	// ****************************************
	localparam int SEC_CYC   = CLK_HZ / `RMS_OUT_RATE_HZ;          // One output period
	localparam int BLINK_CYC = CLK_HZ / (2 * `RMS_BLINK_HZ);       // Half blink period
	localparam int TMO_CYC   = (CLK_HZ / 1000) * CORR_TMO_MS;      // Stream timeout
	// One width serves all three dividers, so it must hold the longest count
	localparam int MAX_CYC   = (TMO_CYC > SEC_CYC) ? TMO_CYC : SEC_CYC; // Longest count
	localparam int CW        = $clog2(MAX_CYC + 1);                // Counter width

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]  ctrl;      // Control register
		logic [15:0] sv_time;   // Survey-in minimum seconds
		logic [15:0] sv_acc;    // Survey-in accuracy limit
		logic [3:0]  min_sig;   // Minimum locked signals for fix
		rms_rov_t    rov;       // Rover state
		rms_base_t   base;      // Base state
		logic [CW-1:0] tmo;     // Stream silence counter
		logic        stream;    // Stream present
		logic [CW-1:0] blink_cnt; // Blink divider
		logic        blink;     // Blink phase
		logic [CW-1:0] sec_cnt; // Second divider
		logic [15:0] sv_secs;   // Survey elapsed seconds
		logic        sv_acc_ok; // Accuracy met
		logic [1:0]  out_idx;   // Next base message slot
		logic        out_busy;  // Emitting a burst
		logic        msg_stb;   // Message strobe
		logic [11:0] msg_type;  // Message type
		logic [11:0] last_type; // Last decoded type
		logic [15:0] rej_cnt;   // Rejected frames
		logic        ack;       // Bus acknowledge
		logic [31:0] rdat;      // Read data
	} rms_st_t;

	rms_st_t st_ff;   // Registered state
	rms_st_t nxt_st;  // Next state

	// ****************************************
	// Message type decode
	// ****************************************
	// Rover accepts only the listed types
	function automatic logic rover_accepts(input logic [11:0] t);
		unique case (t)
			12'h3E9, 12'h3EA, 12'h3EB, 12'h3EC, 12'h3ED, 12'h3EE, 12'h3EF,
			12'h3F1, 12'h3F2, 12'h3F3, 12'h3F4,
			12'h433, 12'h435, 12'h43D, 12'h43F, 12'h465, 12'h467: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : rover_accepts

	// Base output slot to message type
	function automatic logic [11:0] base_type(input logic [1:0] i);
		unique case (i)
			2'h0: return 12'h3ED; // Station coordinates
			2'h1: return 12'h435; // GPS observations
			2'h2: return 12'h43F; // GLONASS observations
			2'h3: return 12'h467; // BeiDou observations
		endcase
	endfunction : base_type

	logic is_base;    // Device acts as base
	logic wb_req;     // Bus request active
	logic wr_ctrl;    // Write to control
	logic accepted;   // Valid accepted frame
	logic fix_ok;     // Conditions to fix
	assign is_base  = st_ff.ctrl[`RMS_CTRL_ROLE];
	assign wb_req   = wb_cyc_i && wb_stb_i && !st_ff.ack;
	assign wr_ctrl  = wb_req && wb_we_i && wb_adr_i == `RMS_OFF_CTRL && wb_sel_i[0];
	assign accepted = rx_i.corr_valid && rover_accepts(rx_i.msg_type);
	assign fix_ok   = rx_i.amb_resolved && rx_i.locked_sigs >= st_ff.min_sig
		&& !st_ff.ctrl[`RMS_CTRL_FLOATONLY];

	// ****************************************
	// Next-state logic
	// ****************************************
	// All next-state decisions in one process
	always_comb begin
		nxt_st = st_ff;
		nxt_st.msg_stb = 1'b0;
		nxt_st.ack = 1'b0;
		// Go command stands for one cycle, then clears itself
		nxt_st.ctrl[`RMS_CTRL_CMDGO] = 1'b0;
		// Register writes
		if (wb_req && wb_we_i) begin
			unique case (wb_adr_i)
				`RMS_OFF_CTRL: begin
					if (wb_sel_i[0]) begin
						nxt_st.ctrl = wb_dat_i[7:0]; // Go bit taken, cleared a cycle later
					end
				end
				`RMS_OFF_SVCFG: begin
					if (wb_sel_i[1:0] == 2'h3) begin
						nxt_st.sv_time = wb_dat_i[15:0];
					end
					if (wb_sel_i[3:2] == 2'h3) begin
						nxt_st.sv_acc = wb_dat_i[31:16];
					end
				end
				`RMS_OFF_FILTER: begin
					if (wb_sel_i[0]) begin
						nxt_st.min_sig = wb_dat_i[3:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Register reads, unmapped reads as zero
		if (wb_req) begin
			nxt_st.ack = 1'b1;
			unique case (wb_adr_i)
				`RMS_OFF_CTRL:    nxt_st.rdat = {24'h000000, st_ff.ctrl};
				`RMS_OFF_SVCFG:   nxt_st.rdat = {st_ff.sv_acc, st_ff.sv_time};
				`RMS_OFF_STAT:    nxt_st.rdat = {16'h0000, st_ff.sv_secs[11:0], st_ff.stream,
					1'b0, st_ff.rov}; // Exactly 32 bits wide
				`RMS_OFF_MSGTYPE: nxt_st.rdat = {4'h0, st_ff.last_type, st_ff.rej_cnt};
				`RMS_OFF_FILTER:  nxt_st.rdat = {28'h0000000, st_ff.min_sig};
				`RMS_OFF_BASEOUT: nxt_st.rdat = {20'h00000, st_ff.msg_type};
				default:          nxt_st.rdat = 32'h00000000;
			endcase
		end
		// Stream presence: valid accepted frames rearm the timeout in rover role only
		if (accepted && !is_base) begin
			nxt_st.tmo = CW'(TMO_CYC);
			nxt_st.stream = 1'b1;
			nxt_st.last_type = rx_i.msg_type;
		end else if (st_ff.tmo != '0) begin
			nxt_st.tmo = st_ff.tmo - CW'(1);
		end else begin
			nxt_st.stream = 1'b0;
		end
		if (rx_i.corr_valid && !rover_accepts(rx_i.msg_type)) begin
			nxt_st.rej_cnt = st_ff.rej_cnt + 16'h0001; // Ignored frame counted
		end
		// Blink divider
		if (st_ff.blink_cnt == '0) begin
			nxt_st.blink_cnt = CW'(BLINK_CYC - 1);
			nxt_st.blink = !st_ff.blink;
		end else begin
			nxt_st.blink_cnt = st_ff.blink_cnt - CW'(1);
		end
		// Rover state machine
		unique case (st_ff.rov)
			RMS_ROV_STD: begin
				if (st_ff.stream && !is_base) begin
					nxt_st.rov = RMS_ROV_FLOAT;
				end
			end
			RMS_ROV_FLOAT: begin
				if (!st_ff.stream || is_base) begin
					nxt_st.rov = RMS_ROV_STD;
				end else if (fix_ok) begin
					nxt_st.rov = RMS_ROV_FIXED;
				end
			end
			RMS_ROV_FIXED: begin
				if (!st_ff.stream || is_base) begin
					nxt_st.rov = RMS_ROV_STD;
				end else if (rx_i.locked_sigs < st_ff.min_sig || st_ff.ctrl[`RMS_CTRL_FLOATONLY]) begin
					nxt_st.rov = RMS_ROV_FLOAT;
				end
			end
		endcase
		// Second tick
		if (st_ff.sec_cnt == '0) begin
			nxt_st.sec_cnt = CW'(SEC_CYC - 1);
		end else begin
			nxt_st.sec_cnt = st_ff.sec_cnt - CW'(1);
		end
		// Base state machine
		unique case (st_ff.base)
			RMS_BASE_STD: begin
				if (is_base && st_ff.ctrl[`RMS_CTRL_CMDGO]) begin
					nxt_st.sv_secs = 16'h0000;
					nxt_st.sv_acc_ok = 1'b0;
					if (st_ff.ctrl[`RMS_CTRL_MODE_HI:`RMS_CTRL_MODE_LO] == `RMS_BMODE_FIXED) begin
						nxt_st.base = RMS_BASE_FIXED;
					end else if (st_ff.ctrl[`RMS_CTRL_MODE_HI:`RMS_CTRL_MODE_LO] == `RMS_BMODE_SURVEY) begin
						nxt_st.base = RMS_BASE_SURVEY;
					end
				end
			end
			RMS_BASE_SURVEY: begin
				if (rx_i.pos_valid) begin
					nxt_st.sv_acc_ok = rx_i.pos_acc <= st_ff.sv_acc;
				end
				if (st_ff.sec_cnt == '0 && st_ff.sv_secs != 16'hFFFF) begin
					nxt_st.sv_secs = st_ff.sv_secs + 16'h0001;
				end
				if (st_ff.sv_acc_ok && st_ff.sv_secs >= st_ff.sv_time) begin
					nxt_st.base = RMS_BASE_FIXED;
				end
				if (!is_base) begin
					nxt_st.base = RMS_BASE_STD;
				end
			end
			RMS_BASE_FIXED: begin
				if (!is_base) begin
					nxt_st.base = RMS_BASE_STD;
				end
			end
		endcase
		// Base output burst once per second, only when fixed
		if (st_ff.base == RMS_BASE_FIXED && st_ff.sec_cnt == '0) begin
			nxt_st.out_busy = 1'b1;
			nxt_st.out_idx = 2'h0;
		end else if (st_ff.out_busy) begin
			nxt_st.msg_stb = 1'b1;
			nxt_st.msg_type = base_type(st_ff.out_idx);
			nxt_st.out_idx = st_ff.out_idx + 2'h1;
			if (st_ff.out_idx == 2'h3) begin
				nxt_st.out_busy = 1'b0;
			end
		end
		if (st_ff.base != RMS_BASE_FIXED) begin
			nxt_st.out_busy = 1'b0;
			nxt_st.msg_stb = 1'b0;  // A cut burst stops at once
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// One register for all state, synchronous reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '{ctrl: `RMS_CTRL_RESET, sv_time: `RMS_SVTIME_RESET, sv_acc: `RMS_SVACC_RESET,
				min_sig: `RMS_MINSIG_RESET, rov: RMS_ROV_STD, base: RMS_BASE_STD, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Status pin: low when fixed, blinking with a stream, else high
	always_comb begin
		if (st_ff.rov == RMS_ROV_FIXED) begin
			corr_status_n_o = 1'b0;
		end else if (st_ff.stream) begin
			corr_status_n_o = st_ff.blink;
		end else begin
			corr_status_n_o = 1'b1;
		end
	end
	// Plain gates and register views
	assign raw_meas_en_o    = rx_i.bit_sync && rx_i.tow_valid;
	assign nav_payload_en_o = rx_i.bit_sync && rx_i.frame_sync;
	assign ned_rel_o        = st_ff.rov != RMS_ROV_STD;
	assign coord_ecef_o     = st_ff.ctrl[`RMS_CTRL_COORD];
	assign gnss_sel_o       = st_ff.ctrl[`RMS_CTRL_GNSS_HI:`RMS_CTRL_GNSS_LO];
	assign base_msg_stb_o   = st_ff.msg_stb;
	assign base_msg_type_o  = st_ff.msg_type;
	assign wb_dat_o         = st_ff.rdat;
	assign wb_ack_o         = st_ff.ack;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Rover transitions and decode filter
	a_float_entry: assert property (st_ff.rov == RMS_ROV_STD && st_ff.stream && !is_base
		|=> st_ff.rov == RMS_ROV_FLOAT) else $error("Rover missed float entry");
	a_fix_entry: assert property (st_ff.rov == RMS_ROV_FLOAT && st_ff.stream && !is_base && fix_ok
		|=> st_ff.rov == RMS_ROV_FIXED) else $error("Rover missed fix");
	a_lock_drop: assert property (st_ff.rov == RMS_ROV_FIXED && st_ff.stream && !is_base
		&& rx_i.locked_sigs < st_ff.min_sig |=> st_ff.rov == RMS_ROV_FLOAT)
		else $error("No drop to float");
	a_refix_cond: assert property ($rose(st_ff.rov == RMS_ROV_FIXED) |-> $past(fix_ok))
		else $error("Fix without conditions");
	a_stream_loss: assert property (!st_ff.stream
		|=> st_ff.rov == RMS_ROV_STD || $past(st_ff.rov) == RMS_ROV_STD)
		else $error("Rover kept differential state");
	a_float_only: assert property (st_ff.ctrl[`RMS_CTRL_FLOATONLY]
		|=> st_ff.rov != RMS_ROV_FIXED || $past(st_ff.rov) == RMS_ROV_FIXED)
		else $error("Fixed while float-only");
	a_stream_rearm: assert property (accepted && !is_base |=> st_ff.stream)
		else $error("Accepted frame did not raise stream");
	a_type_filter: assert property (rx_i.corr_valid && !rover_accepts(rx_i.msg_type)
		|=> $stable(st_ff.last_type)) else $error("Filtered type was taken");

	// Status pin
	a_pin_fixed: assert property (st_ff.rov == RMS_ROV_FIXED |-> !corr_status_n_o)
		else $error("Pin not low in fixed");
	a_pin_idle: assert property (!st_ff.stream && st_ff.rov != RMS_ROV_FIXED |-> corr_status_n_o)
		else $error("Pin not high without stream");
	a_blink_pin: assert property (st_ff.stream && st_ff.rov != RMS_ROV_FIXED
		|-> corr_status_n_o == st_ff.blink) else $error("Pin not blinking with stream");

	// Base sequencing and output
	a_base_quiet: assert property (st_ff.base != RMS_BASE_FIXED |=> !base_msg_stb_o)
		else $error("Base output before mode set");
	a_burst_order: assert property ($rose(base_msg_stb_o) |-> base_msg_type_o == 12'h3ED
		##1 base_msg_type_o == 12'h435 ##1 base_msg_type_o == 12'h43F ##1 base_msg_type_o == 12'h467)
		else $error("Base burst wrong");
	a_go_pulse: assert property (st_ff.ctrl[`RMS_CTRL_CMDGO]
		|-> $past(wr_ctrl) ##1 !st_ff.ctrl[`RMS_CTRL_CMDGO]) else $error("Go command not a pulse");
	a_leave_std: assert property ($past(st_ff.base) == RMS_BASE_STD && st_ff.base != RMS_BASE_STD
		|-> $past(is_base && st_ff.ctrl[`RMS_CTRL_CMDGO])) else $error("Base left standard without go");
	a_survey_exit: assert property ($past(st_ff.base) == RMS_BASE_SURVEY
		&& st_ff.base == RMS_BASE_FIXED |-> $past(st_ff.sv_acc_ok && st_ff.sv_secs >= st_ff.sv_time))
		else $error("Survey ended early");
	a_burst_tick: assert property ($rose(st_ff.out_busy) |-> $past(st_ff.sec_cnt) == '0)
		else $error("Burst off the second tick");
	a_fixed_out: assert property (st_ff.base == RMS_BASE_FIXED && is_base && st_ff.sec_cnt == '0
		|-> ##2 base_msg_stb_o && base_msg_type_o == 12'h3ED)
		else $error("Fixed base silent on the tick");

	// Output gates
	a_raw_gate: assert property (raw_meas_en_o |-> rx_i.bit_sync && rx_i.tow_valid)
		else $error("Raw output ungated");

	// Main scenarios
	c_float: cover property (st_ff.rov == RMS_ROV_FLOAT ##1 st_ff.rov == RMS_ROV_FIXED);
	c_refloat: cover property (st_ff.rov == RMS_ROV_FIXED ##1 st_ff.rov == RMS_ROV_FLOAT);
	c_survey: cover property (st_ff.base == RMS_BASE_SURVEY ##1 st_ff.base == RMS_BASE_FIXED);
	c_burst: cover property ($rose(base_msg_stb_o));
	c_blink: cover property (st_ff.stream && $changed(corr_status_n_o));
endmodule : rms_mode_seq
`default_nettype wire

// ===== bench/rms_peer_model.sv
// Peer receiver model: paces correction frames and position estimates toward the rover
`timescale 1ns/1ps
`default_nettype none
module rms_peer_model
	import rms_pkg::*;
(
	input  wire logic    clk_i,       // System clock
	input  wire logic    rst_i,       // Synchronous reset
	input  wire logic    stream_en_i, // Send correction frames
	input  wire rms_rx_t lvl_i,       // Levels, frame type and accuracy
	output var  rms_rx_t rx_o         // Status toward the design
);
	// ****************************************
	// Pacing state
	// ****************************************
	logic [2:0]  cnt_ff;  // Pacing counter
	logic [11:0] last_ff; // Type of the last frame sent
	// Free-running pacing and memory of the last frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 3'h0;
			last_ff <= 12'h000;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
			if (rx_o.corr_valid) last_ff <= rx_o.msg_type;
		end
	end
	// Frame every fourth cycle, just inside the bench's five-cycle stream timeout; estimate every eighth
	always_comb begin
		rx_o = lvl_i;
		rx_o.corr_valid = stream_en_i && !rst_i && (cnt_ff[1:0] == 2'h0);
		rx_o.pos_valid = !rst_i && (cnt_ff == 3'h7);
		// Between frames the type line carries junk, never the old value
		if (!rx_o.corr_valid) rx_o.msg_type = ~last_ff;
	end
endmodule : rms_peer_model
`default_nettype wire

// ===== bench/rms_mode_seq_bench.sv
// Testbench: mode sequencer checked against expected values, with a behavioural model for the decode filter
`timescale 1ns/1ps
`default_nettype none
`include "rms_cfg.svh"
module rms_mode_seq_bench
	import rms_pkg::*;
();
	// ****************************************
	// Signals, model state and instances
	// ****************************************
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, stream_en; // Clock, reset, bus, stream
	logic [7:0]  wb_adr;                                  // Bus address
	logic [31:0] wb_wdat, wb_rdat;                        // Bus data
	logic        pin_n, raw_en, pay_en, ned, ecef, bstb;  // Design flags
	logic [1:0]  gsel;                                    // Constellation select
	logic [11:0] btype;                                   // Emitted base type
	rms_rx_t     lvl, rx;                                 // Levels in, status to design
	int          err_count, samples_checked, m_rej, m_last; // Counters and model
	int          acc_q[$] = '{1001, 1002, 1003, 1004, 1005, 1006, 1007, 1009, 1010, 1011, 1012,
		1075, 1077, 1085, 1087, 1125, 1127};              // Decodable types
	int          out_q[$] = '{1005, 1077, 1087, 1127};    // Base burst order
	rms_mode_seq #(.CLK_HZ(1000), .CORR_TMO_MS(5)) rms_mode_seq_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.rx_i(rx), .corr_status_n_o(pin_n), .raw_meas_en_o(raw_en), .nav_payload_en_o(pay_en),
		.ned_rel_o(ned), .coord_ecef_o(ecef), .gnss_sel_o(gsel), .base_msg_stb_o(bstb),
		.base_msg_type_o(btype));
	rms_peer_model rms_peer_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stream_en_i(stream_en),
		.lvl_i(lvl), .rx_o(rx));
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	function automatic bit ok_type(input int t);
		foreach (acc_q[i]) if (acc_q[i] == t) return 1'b1;
		return 1'b0;
	endfunction : ok_type
	// Decode filter model, fed from the frames on the status bus
	always @(posedge clk_i) begin
		if (rst_i) begin
			m_rej = 0;
			m_last = 0;
		end else if (rx.corr_valid === 1'b1) begin
			if (ok_type(int'(rx.msg_type))) m_last = int'(rx.msg_type);
			else m_rej++;
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			err_count++;
			stop_test();
		end else begin
			q = wb_rdat;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
			wb_we <= 1'b0;
		end
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check($sformatf("register %h", a), q, e);
	endtask : rchk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic fixchk(input logic e);
		logic [31:0] q;
		wb(1'b0, `RMS_OFF_STAT, 32'h0, q);
		check("fixed state", {31'h0, q[1]}, {31'h0, e});
	endtask : fixchk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// Waits up to lim cycles for an emission strobe; time or -1
	task automatic wait_stb(input int lim, output longint at);
		at = -1;
		for (int i = 0; i < lim && at < 0; i++) begin
			@(posedge clk_i);
			if (bstb === 1'b1) at = $time;
		end
	endtask : wait_stb
	task automatic send_type(input int t);
		lvl.msg_type <= 12'(t);
		stream_en <= 1'b1;
		tick(9);
		stream_en <= 1'b0;
		tick(3);
		rchk(`RMS_OFF_MSGTYPE, {4'h0, m_last[11:0], m_rej[15:0]});
	endtask : send_type
	task automatic burst;
		foreach (out_q[k]) begin
			if (k > 0) @(posedge clk_i);
			check("burst strobe", {31'h0, bstb}, 1);
			check("burst type", {20'h0, btype}, out_q[k]);
		end
		@(posedge clk_i);
		check("burst end", {31'h0, bstb}, 0);
	endtask : burst
	task automatic do_reset;
		rst_i <= 1'b1;
		stream_en <= 1'b0;
		tick(20);
		rst_i <= 1'b0;
	endtask : do_reset
	task automatic done(input string s);
		$display("test %s finished, mismatches so far %0d", s, err_count);
	endtask : done
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		longint t1, t2;
		int n, t;
		logic p;
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		stream_en = 1'b0;
		lvl = '0;
		void'($urandom(32'h54B94BBC));
		do_reset();
		rchk(`RMS_OFF_CTRL, 32'h0000_00C0);
		rchk(`RMS_OFF_SVCFG, 32'h0100_003C);
		rchk(`RMS_OFF_FILTER, 32'h0000_0004);
		wr(8'h1C, 32'hFFFF_FFFF);
		rchk(8'h1C, 32'h0);
		check("pin idle", {31'h0, pin_n}, 1);
		check("gnss", {30'h0, gsel}, 3);
		done("reset");
		// Every decodable type, the type just below the range, the gap type 1008, random others
		lvl.locked_sigs <= 4'h4;
		foreach (acc_q[i]) send_type(acc_q[i]);
		send_type(1000);
		send_type(1008);
		repeat (3) begin
			do t = int'($urandom % 4096); while (ok_type(t));
			send_type(t);
		end
		done("decode");
		// Rover walk through float, fixed, lock loss and float-only
		lvl.msg_type <= 12'd1077;
		stream_en <= 1'b1;
		tick(10);
		check("relative report", {31'h0, ned}, 1);
		fixchk(1'b0);
		lvl.amb_resolved <= 1'b1;
		lvl.locked_sigs <= 4'(4 + $urandom % 12);
		tick(10);
		fixchk(1'b1);
		repeat (3) begin
			tick(100);
			check("pin fixed", {31'h0, pin_n}, 0);
		end
		lvl.locked_sigs <= 4'h3;
		tick(10);
		fixchk(1'b0);
		lvl.locked_sigs <= 4'h4;
		tick(10);
		fixchk(1'b1);
		wr(`RMS_OFF_CTRL, 32'h0000_00C2);
		lvl.locked_sigs <= 4'h3;
		tick(10);
		lvl.locked_sigs <= 4'hF;
		tick(10);
		fixchk(1'b0);
		n = 0;
		p = pin_n;
		repeat (1100) begin
			@(posedge clk_i);
			if (pin_n !== p) n++;
			p = pin_n;
		end
		check("blink edges", {31'h0, n >= 4}, 1);
		stream_en <= 1'b0;
		tick(20);
		check("relative off", {31'h0, ned}, 0);
		check("pin off", {31'h0, pin_n}, 1);
		done("rover");
		for (int i = 0; i < 8; i++) begin
			lvl.bit_sync <= i[0];
			lvl.tow_valid <= i[1];
			lvl.frame_sync <= i[2];
			tick(2);
			check("raw enable", {31'h0, raw_en}, {31'h0, i[0] & i[1]});
			check("payload enable", {31'h0, pay_en}, {31'h0, i[0] & i[2]});
		end
		for (int g = 0; g < 4; g++) begin
			if (g == 2) continue;
			wr(`RMS_OFF_CTRL, 32'(g * 64 + (g % 2) * 32));
			tick(2);
			check("gnss", {30'h0, gsel}, g);
			check("ecef", {31'h0, ecef}, g % 2);
		end
		done("config");
		// Base with known coordinates, two bursts one second apart
		do_reset();
		wait_stb(1200, t1);
		check("base quiet", {31'h0, t1 < 0}, 1);
		wr(`RMS_OFF_CTRL, 32'h0000_00D5);
		wait_stb(1100, t1);
		check("base first", {31'h0, t1 >= 0}, 1);
		burst();
		wait_stb(1100, t2);
		check("burst gap", 32'(t2 - t1), 32'd50000);
		burst();
		done("base fixed");
		// Survey-in: accuracy at the limit waits out the time; one above never finishes
		for (int k = 0; k < 2; k++) begin
			do_reset();
			wr(`RMS_OFF_SVCFG, 32'h0100_0002);
			lvl.pos_acc <= 16'(16'h0100 + k);
			wr(`RMS_OFF_CTRL, 32'h0000_00CD);
			wait_stb(1800, t1);
			check("survey early", {31'h0, t1 < 0}, 1);
			wait_stb(1500, t1);
			check("survey done", {31'h0, t1 >= 0}, {31'h0, k == 0});
		end
		done("survey");
		stop_test();
	end
endmodule : rms_mode_seq_bench
`default_nettype wire
